// >>> ipwm_map.svh
// register map, field positions and constants of the 8-bit interval/pwm timer
`ifndef IPWM_MAP_SVH
`define IPWM_MAP_SVH

`define IPWM_ADDR_W         16
`define IPWM_OFS_MODE       16'hff10
`define IPWM_OFS_PERIOD     16'hff11
`define IPWM_OFS_DUTY       16'hff12
`define IPWM_OFS_STATUS     16'hff13
`define IPWM_OFS_PORT1_DIR  16'hff21
`define IPWM_OFS_PORT1_LAT  16'hff01

`define IPWM_BIT_OUT_EN     0
`define IPWM_BIT_IDLE_LEV   1
`define IPWM_LSB_MODE       2
`define IPWM_LSB_CLKSEL     4
`define IPWM_BIT_RUN        7

`define IPWM_MODE_INTERVAL  2'b00
`define IPWM_MODE_PWM       2'b10
`define IPWM_PORT1_DIR_RST  8'hff
`define IPWM_DUTY_SYNC_CLKS 2'd3
`define IPWM_PIN_OUT0       5
`define IPWM_PIN_OUT1       6

`endif

// >>> ipwm_pkg.sv
// types shared by the interval/pwm timer
package ipwm_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } ipwm_bus_req_t;

    typedef enum logic [1:0] {
        IPWM_IDLE = 2'b00,
        IPWM_SKIP = 2'b01,
        IPWM_CNT  = 2'b11
    } ipwm_state_t;
endpackage

// >>> ipwm_clk_div.sv
// count clock enable divider selected by the clock select field
`timescale 1ns/1ps
`default_nettype none
module ipwm_clk_div (
    input  wire logic       core_clk,  // system clock
    input  wire logic       sys_rst,   // async reset, high
    input  wire logic       run,       // divider runs only while counting
    input  wire logic [2:0] sel,       // clock select field
    output logic            cnt_en     // one-cycle count enable
);
    import ipwm_pkg::*;

    typedef struct packed {
        logic [11:0] div;
        logic        en;
    } ipwm_div_st_t;

    ipwm_div_st_t st_reg;
    ipwm_div_st_t st_next;

    // divide exponents 0,2,4,6,12,7,9,3; the low-speed source is not modelled
    function automatic logic [11:0] ipwm_mask(input logic [2:0] s);
        case (s)
            3'd0:    ipwm_mask = 12'h000;
            3'd1:    ipwm_mask = 12'h003;
            3'd2:    ipwm_mask = 12'h00f;
            3'd3:    ipwm_mask = 12'h03f;
            3'd4:    ipwm_mask = 12'hfff;
            3'd5:    ipwm_mask = 12'h07f;
            3'd6:    ipwm_mask = 12'h1ff;
            default: ipwm_mask = 12'h007;
        endcase
    endfunction

    always_comb begin
        st_next = st_reg;
        st_next.en = 1'b0;
        if (!run) begin
            st_next.div = 12'h000;
        end else if ((st_reg.div & ipwm_mask(sel)) == ipwm_mask(sel)) begin
            st_next.div = 12'h000;
            st_next.en  = 1'b1;
        end else begin
            st_next.div = st_reg.div + 12'h001;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cnt_en = st_reg.en;
endmodule
`default_nettype wire

// >>> ipwm_timer.sv
// 8-bit interval / pwm timer with register port and port 1 direction
`timescale 1ns/1ps
`default_nettype none
`include "ipwm_map.svh"
module ipwm_timer (
    input  wire logic                   core_clk,     // 50 mhz clock
    input  wire logic                   sys_rst,      // async reset, high
    input  wire ipwm_pkg::ipwm_bus_req_t bus_req,     // register request
    output logic [7:0]                  rdata,        // read data, cycle after read
    output logic                        match_irq,    // period match pulse
    output logic                        timer_output, // timer output level
    output logic [7:0]                  port1_oe,     // port 1 driver enables
    output logic [7:0]                  port1_out     // port 1 pin values
);
    import ipwm_pkg::*;

    typedef struct packed {
        logic [7:0]  mode;
        logic [7:0]  period;
        logic [7:0]  duty;
        logic [7:0]  duty_pend;
        logic        pend;
        logic [1:0]  sync_cnt;
        logic [7:0]  port1_dir;
        logic [7:0]  port1_lat;
        logic [7:0]  count;
        logic        cmp_duty;
        ipwm_state_t state;
        logic        active;
        logic        irq;
        logic        tout;
        logic [7:0]  rdata;
        logic [7:0]  p_oe;
        logic [7:0]  p_out;
    } ipwm_st_t;

    ipwm_st_t st_reg;
    ipwm_st_t st_next;
    logic     cnt_en;
    logic     run_bit;
    logic     is_pwm;
    logic     out_en;
    logic     idle_lev;

    assign run_bit  = st_reg.mode[`IPWM_BIT_RUN];
    assign is_pwm   = st_reg.mode[`IPWM_LSB_MODE+1 -: 2] == `IPWM_MODE_PWM;
    assign out_en   = st_reg.mode[`IPWM_BIT_OUT_EN];
    assign idle_lev = st_reg.mode[`IPWM_BIT_IDLE_LEV];

    ipwm_clk_div u_div (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .run      (run_bit),
        .sel      (st_reg.mode[`IPWM_LSB_CLKSEL +: 3]),
        .cnt_en   (cnt_en)
    );

    function automatic logic ipwm_hit(input logic [15:0] a, input logic [15:0] ofs);
        ipwm_hit = a == ofs;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic       wr_duty;
        logic       pmatch;
        logic       dmatch;
        logic       tout_n;
        wr_duty = 1'b0;
        pmatch  = 1'b0;
        dmatch  = 1'b0;
        tout_n  = 1'b0;
        st_next = st_reg;
        st_next.irq = 1'b0;

        // register writes; mode bits other than run are locked while running
        if (bus_req.wr) begin
            if (ipwm_hit(bus_req.addr, `IPWM_OFS_MODE)) begin
                if (run_bit) begin
                    st_next.mode[`IPWM_BIT_RUN] = bus_req.wdata[`IPWM_BIT_RUN];
                end else begin
                    st_next.mode = bus_req.wdata;
                end
            end
            if (ipwm_hit(bus_req.addr, `IPWM_OFS_PERIOD)) begin
                st_next.period = bus_req.wdata;
            end
            if (ipwm_hit(bus_req.addr, `IPWM_OFS_DUTY)) begin
                wr_duty = 1'b1;
            end
            if (ipwm_hit(bus_req.addr, `IPWM_OFS_PORT1_DIR)) begin
                st_next.port1_dir = bus_req.wdata;
            end
            if (ipwm_hit(bus_req.addr, `IPWM_OFS_PORT1_LAT)) begin
                st_next.port1_lat = bus_req.wdata;
            end
        end

        // duty writes while running are latched, then moved at a duty match after three count clocks; stopped writes load at once
        if (wr_duty) begin
            st_next.duty_pend = bus_req.wdata;
            st_next.pend      = 1'b1;
            st_next.sync_cnt  = 2'd0;
            if (!run_bit) begin
                st_next.duty = bus_req.wdata;
                st_next.pend = 1'b0;
            end
        end else if (st_reg.pend && cnt_en && st_reg.sync_cnt != `IPWM_DUTY_SYNC_CLKS) begin
            st_next.sync_cnt = st_reg.sync_cnt + 2'd1;
        end

        case (st_reg.state)
            IPWM_IDLE: begin
                st_next.count    = 8'h00;
                st_next.cmp_duty = 1'b0;
                st_next.active   = 1'b0;
                if (run_bit) begin
                    // pwm masks the first count clock
                    st_next.state = is_pwm ? IPWM_SKIP : IPWM_CNT;
                end
            end
            IPWM_SKIP: begin
                if (!run_bit) begin
                    st_next.state = IPWM_IDLE;
                end else if (cnt_en) begin
                    st_next.state = IPWM_CNT;
                end
            end
            IPWM_CNT: begin
                if (!run_bit) begin
                    st_next.state  = IPWM_IDLE;
                    st_next.count  = 8'h00;
                    st_next.active = 1'b0;
                end else if (cnt_en) begin
                    pmatch = !st_reg.cmp_duty && st_reg.count == st_reg.period;
                    dmatch = is_pwm && st_reg.cmp_duty && st_reg.count == st_reg.duty;
                    if (pmatch) begin
                        st_next.count = 8'h00;
                        st_next.irq   = 1'b1;
                        if (is_pwm) begin
                            st_next.active   = 1'b1;
                            st_next.cmp_duty = 1'b1;
                        end else begin
                            st_next.active = !st_reg.active;
                        end
                    end else begin
                        st_next.count = st_reg.count + 8'h01;
                    end
                    if (dmatch) begin
                        st_next.active   = 1'b0;
                        st_next.cmp_duty = 1'b0;
                    end
                    // a pending duty moves on a duty match once settled
                    if (dmatch && st_reg.pend && st_reg.sync_cnt == `IPWM_DUTY_SYNC_CLKS) begin
                        st_next.duty = st_reg.duty_pend;
                        st_next.pend = 1'b0;
                    end
                end
            end
            default: begin
                st_next.state = IPWM_IDLE;
            end
        endcase

        // output gated by enable; idle level sets polarity
        tout_n = out_en && st_next.active;
        st_next.tout = tout_n ^ idle_lev;

        // pins 5 and 6 carry the timer output when their latch is zero
        st_next.p_oe  = ~st_next.port1_dir;
        st_next.p_out = st_next.port1_lat;
        st_next.p_out[`IPWM_PIN_OUT0] = st_next.port1_lat[`IPWM_PIN_OUT0] | st_next.tout;
        st_next.p_out[`IPWM_PIN_OUT1] = st_next.port1_lat[`IPWM_PIN_OUT1] | st_next.tout;

        st_next.rdata = 8'h00;
        if (bus_req.rd) begin
            if (ipwm_hit(bus_req.addr, `IPWM_OFS_MODE)) st_next.rdata = st_reg.mode;
            if (ipwm_hit(bus_req.addr, `IPWM_OFS_PERIOD)) st_next.rdata = st_reg.period;
            if (ipwm_hit(bus_req.addr, `IPWM_OFS_DUTY)) st_next.rdata = st_reg.duty;
            if (ipwm_hit(bus_req.addr, `IPWM_OFS_STATUS)) st_next.rdata = st_reg.count;
            if (ipwm_hit(bus_req.addr, `IPWM_OFS_PORT1_DIR)) st_next.rdata = st_reg.port1_dir;
            if (ipwm_hit(bus_req.addr, `IPWM_OFS_PORT1_LAT)) st_next.rdata = st_reg.port1_lat;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg           <= '0;
            st_reg.state     <= IPWM_IDLE;
            st_reg.port1_dir <= `IPWM_PORT1_DIR_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata        = st_reg.rdata;
    assign match_irq    = st_reg.irq;
    assign timer_output = st_reg.tout;
    assign port1_oe     = st_reg.p_oe;
    assign port1_out    = st_reg.p_out;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_stop_clears_count: assert property (@(posedge core_clk) disable iff (sys_rst)
        !run_bit |=> st_reg.count == 8'h00) else $error("count not cleared when stopped");
    a_stop_kills_out: assert property (@(posedge core_clk) disable iff (sys_rst)
        $fell(run_bit) |=> !match_irq && timer_output == idle_lev)
        else $error("output not inactive after stop");
    a_pwm_stop_out: assert property (@(posedge core_clk) disable iff (sys_rst)
        (is_pwm && !run_bit) |=> !st_reg.active) else $error("pwm active while stopped");
    a_period_match_irq: assert property (@(posedge core_clk) disable iff (sys_rst)
        (st_reg.state == IPWM_CNT && run_bit && cnt_en && !st_reg.cmp_duty
         && st_reg.count == st_reg.period) |=> match_irq && st_reg.count == 8'h00)
        else $error("period match missed");
    a_duty_no_irq: assert property (@(posedge core_clk) disable iff (sys_rst)
        (st_reg.state == IPWM_CNT && run_bit && cnt_en && st_reg.cmp_duty && is_pwm
         && st_reg.count == st_reg.duty) |=> !match_irq && !st_reg.active && !st_reg.cmp_duty)
        else $error("duty match wrong");
    a_pwm_active_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        (match_irq && is_pwm && run_bit) |-> st_reg.active && st_reg.cmp_duty)
        else $error("pwm match did not activate");
    a_interval_no_duty: assert property (@(posedge core_clk) disable iff (sys_rst)
        !is_pwm |-> !st_reg.cmp_duty) else $error("duty compare used in interval");
    a_interval_toggle: assert property (@(posedge core_clk) disable iff (sys_rst)
        (match_irq && !is_pwm && run_bit && !$past(st_reg.irq)) |-> st_reg.active != $past(st_reg.active))
        else $error("no toggle on interval match");
    a_skip_first_clk: assert property (@(posedge core_clk) disable iff (sys_rst)
        (st_reg.state == IPWM_SKIP) |-> st_reg.count == 8'h00 && !st_reg.active)
        else $error("counting during skip");
    a_dir_enables: assert property (@(posedge core_clk) disable iff (sys_rst)
        port1_oe == ~$past(st_next.port1_dir)) else $error("port enable mismatch");
endmodule
`default_nettype wire

// >>> ipwm_load.sv
// external load on the timer output pin: measures high width and cycle span
`timescale 1ns/1ps
`default_nettype none
module ipwm_load (
    input  wire logic        core_clk,   // system clock
    input  wire logic        drive_en,   // pin driver enabled
    input  wire logic        drive_val,  // pin value while driven
    output logic      [15:0] hi_w,       // last high width in cycles
    output logic      [15:0] per_w       // last rise-to-rise span in cycles
);
    logic        pin;
    logic        pin_d = 1'b1;
    logic [15:0] hcnt  = 16'h0000;
    logic [15:0] pcnt  = 16'h0000;

    // a released pin floats to its pull-up, so it never shows a stale level
    assign pin = drive_en ? drive_val : 1'b1;

    initial begin
        hi_w  = 16'h0000;
        per_w = 16'h0000;
    end

    always @(posedge core_clk) begin
        pin_d <= pin;
        if (pin && !pin_d) begin
            per_w <= pcnt;
            pcnt  <= 16'h0001;
            hcnt  <= 16'h0001;
        end else begin
            pcnt <= pcnt + 16'h0001;
            if (pin) begin
                hcnt <= hcnt + 16'h0001;
            end
        end
        if (!pin && pin_d) begin
            hi_w <= hcnt;
        end
    end
endmodule
`default_nettype wire

// >>> tb_top.sv
// self-checking bench of the interval/pwm timer
`timescale 1ns/1ps
`default_nettype none
`include "ipwm_map.svh"
module tb_top;
    import ipwm_pkg::*;
    logic          core_clk = 1'b0;
    logic          sys_rst = 1'b1;
    ipwm_bus_req_t bus_req = '0;
    logic [7:0]    rdata;
    logic          match_irq;
    logic          timer_output;
    logic [7:0]    port1_oe;
    logic [7:0]    port1_out;
    logic [15:0]   hi_w;
    logic [15:0]   per_w;
    int            miscompares = 0;
    int            n_compared = 0;
    integer        seed = 54;
    logic [7:0]    n;
    logic [7:0]    m;
    int            gap;

    always #10 core_clk = ~core_clk;

    ipwm_timer i_ipwm_timer (.core_clk(core_clk), .sys_rst(sys_rst), .bus_req(bus_req),
        .rdata(rdata), .match_irq(match_irq), .timer_output(timer_output),
        .port1_oe(port1_oe), .port1_out(port1_out));

    ipwm_load i_ipwm_load (.core_clk(core_clk), .drive_en(port1_oe[`IPWM_PIN_OUT0]),
        .drive_val(port1_out[`IPWM_PIN_OUT0]), .hi_w(hi_w), .per_w(per_w));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] span(input logic [7:0] v);
        return {8'h00, v} + 16'h0001;
    endfunction

    task automatic stop_test();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req <= '0;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req <= '0;
        #1;
        chk("rdata", {8'h00, e}, {8'h00, rdata});
    endtask

    // waits for the next match pulse, bounded, and returns the cycles waited
    task automatic wait_irq(output int cyc);
        cyc = 0;
        do begin
            @(posedge core_clk);
            #1;
            cyc++;
        end while (match_irq !== 1'b1 && cyc < 2000);
        if (cyc >= 2000) begin
            miscompares++;
            $display("ERROR match pulse missing");
            stop_test();
        end
    endtask

    task automatic trial(input logic [7:0] mode, input logic [15:0] e_hi,
                         input logic [15:0] e_per);
        wr(`IPWM_OFS_PERIOD, n);
        wr(`IPWM_OFS_DUTY, m);
        wr(`IPWM_OFS_MODE, mode);
        repeat (4) wait_irq(gap);
        chk("match gap", span(n), 16'(gap));
        chk("high width", e_hi, hi_w);
        chk("cycle span", e_per, per_w);
    endtask

    task automatic halt(input logic [7:0] mode);
        wr(`IPWM_OFS_MODE, mode & 8'h7f);
        @(posedge core_clk);
        #1;
        chk("output after stop", 16'h0000, {15'h0, timer_output});
        chk("match after stop", 16'h0000, {15'h0, match_irq});
        rd_chk(`IPWM_OFS_STATUS, 8'h00);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1;
        chk("port1_oe", 16'h0000, {8'h00, port1_oe});
        rd_chk(`IPWM_OFS_PORT1_DIR, `IPWM_PORT1_DIR_RST);
        rd_chk(16'hff30, 8'h00);
        wr(`IPWM_OFS_PORT1_DIR, 8'h9f);
        wr(`IPWM_OFS_PORT1_LAT, 8'h00);
        #1;
        chk("port1_oe", 16'h0060, {8'h00, port1_oe});
        wr(`IPWM_OFS_MODE, 8'h0b);
        @(posedge core_clk);
        #1;
        chk("idle level", 16'h0001, {15'h0, timer_output});
        for (int i = 0; i < 4; i++) begin
            // first pass is the tightest legal pair, the rest are random
            n = (i == 0) ? 8'h01 : 8'h02 + 8'($unsigned($random(seed)) % 60);
            m = (i == 0) ? 8'h00 : 8'($unsigned($random(seed)) % n);
            trial(8'h81, span(n), 16'(2 * span(n)));
            halt(8'h81);
            trial(8'h89, span(m), span(n));
            m = m >> 1;
            wr(`IPWM_OFS_DUTY, m);
            repeat (4) wait_irq(gap);
            chk("new high width", span(m), hi_w);
            halt(8'h89);
        end
        stop_test();
    end

    initial begin
        #1_500_000;
        miscompares++;
        $display("ERROR watchdog expired");
        stop_test();
    end
endmodule
`default_nettype wire
